// ---- design/pic_channel.sv ----
// One pulse counting channel: edge select, integration, overflow, speed window.
// Assumes a qualified input level and single-cycle sample, start and trigger pulses.
`default_nettype none
module pic_channel #(
    parameter int unsigned SLOTS = pic_pkg::WINDOW_SLOTS
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Input and settings
    input  wire logic        level_i,
    input  wire logic        fall_edge_i,
    input  wire logic [1:0]  mode_i,
    input  wire logic        zero_on_trig_i,
    input  wire logic        is_trig_src_i,
    input  wire logic        wrap_i,
    input  wire logic [15:0] range_i,
    input  wire logic [15:0] trig_level_i,
    // Timing events
    input  wire logic        meas_start_i,
    input  wire logic        sample_i,
    input  wire logic        trigger_i,
    input  wire logic        tick_i,
    // Results
    output logic [15:0]      value_o,
    output logic             trig_block_o
);
    localparam int unsigned SW = $clog2(SLOTS);

    logic        level_q;
    logic [15:0] acc_q;
    logic [15:0] out_q;
    logic        trig_seen_q;
    logic        clr_pend_q;
    logic [15:0] slot_cnt_q;
    logic [15:0] slots_q [SLOTS];
    logic [SW-1:0] slot_ptr_q;
    logic [23:0] speed_sum_q;
    logic [15:0] speed_q;
    logic        blk_q;

    wire pic_pkg::pic_mode_t mode = pic_pkg::pic_mode_t'(mode_i);
    wire rise = level_i & ~level_q;
    wire fall = ~level_i & level_q;
    wire edge_hit = fall_edge_i ? fall : rise;
    wire zero_trig = zero_on_trig_i & (mode != pic_pkg::PIC_MODE_SPEED);
    wire [20:0] wrap_lim = 21'(range_i) * 21'(pic_pkg::WRAP_FACTOR);
    wire cum = (mode == pic_pkg::PIC_MODE_ADD);
    wire [16:0] acc_inc = {1'b0, acc_q} + 17'(edge_hit);

    // Next integrated value after one counted edge
    function automatic logic [15:0] acc_next(input logic [16:0] v, input logic c,
                                            input logic w, input logic [20:0] lim);
        logic [15:0] r;
        r = v[15:0];
        if (c && !w && v[16]) begin
            r = pic_pkg::SAT_LIMIT;     // saturate
        end else if (c && w && 21'(v) >= lim) begin
            r = 16'(21'(v) - lim);      // carry over
        end
        return r;
    endfunction

    wire [16:0] slot_inc = {1'b0, slot_cnt_q} + 17'(edge_hit);
    wire [15:0] slot_val = slot_inc[16] ? 16'hFFFF : slot_inc[15:0];
    wire [23:0] sum_next = speed_sum_q + 24'(slot_val) - 24'(slots_q[slot_ptr_q]);

    // Edge history
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level_i;
        end
    end

    // clear at start, clear at the first sample after trigger, one-sample delay
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc_q       <= pic_pkg::VALUE_RESET;
            out_q       <= pic_pkg::VALUE_RESET;
            trig_seen_q <= 1'b0;
            clr_pend_q  <= 1'b0;
        end else if (meas_start_i) begin
            acc_q       <= pic_pkg::VALUE_RESET;
            out_q       <= pic_pkg::VALUE_RESET;
            // A trigger in the start cycle is kept, so it is never lost
            trig_seen_q <= trigger_i && zero_trig;
            clr_pend_q  <= trigger_i && zero_trig;
        end else begin
            if (trigger_i && zero_trig && !trig_seen_q) begin
                trig_seen_q <= 1'b1;
                clr_pend_q  <= 1'b1;
            end
            if (sample_i && clr_pend_q && !trigger_i) begin
                acc_q      <= pic_pkg::VALUE_RESET;
                clr_pend_q <= 1'b0;
            end else if (sample_i && mode == pic_pkg::PIC_MODE_INSTANT) begin
                acc_q <= 16'(edge_hit);
            end else begin
                acc_q <= acc_next(acc_inc, cum, wrap_i, wrap_lim);
            end
            if (sample_i) begin
                if (mode == pic_pkg::PIC_MODE_SPEED) begin
                    out_q <= speed_q;
                end else if (zero_trig && !is_trig_src_i && !(trig_seen_q && !clr_pend_q)) begin
                    out_q <= pic_pkg::VALUE_RESET;
                end else begin
                    out_q <= acc_q;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            slot_cnt_q  <= 16'h0000;
            slot_ptr_q  <= '0;
            speed_sum_q <= 24'h000000;
            speed_q     <= 16'h0000;
        end else if (meas_start_i) begin
            slot_cnt_q  <= 16'h0000;
            slot_ptr_q  <= '0;
            speed_sum_q <= 24'h000000;
            speed_q     <= 16'h0000;
        end else if (tick_i) begin
            slot_cnt_q  <= 16'h0000;
            speed_sum_q <= sum_next;
            speed_q     <= (sum_next > 24'h00FFFF) ? 16'hFFFF : sum_next[15:0];
            slot_ptr_q  <= (32'(slot_ptr_q) == SLOTS - 1) ? '0 : slot_ptr_q + 1'b1;
        end else begin
            slot_cnt_q <= slot_val;
        end
    end

    // Slot memory, cleared at start so the window ramps from zero
    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < SLOTS; i++) begin
            if (meas_start_i) begin
                slots_q[i] <= 16'h0000;
            end
        end
        if (tick_i && !meas_start_i) begin
            slots_q[slot_ptr_q] <= slot_val;
        end
    end

    // block trigger while the saturating total is above level
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= cum && !wrap_i && is_trig_src_i && zero_trig && !trig_seen_q && acc_q > trig_level_i;
        end
    end

    assign value_o      = out_q;
    assign trig_block_o = blk_q;
endmodule
`default_nettype wire

// ---- pkg/pic_pkg.sv ----
// Constants and types shared by the pulse integration counter.
// Assumes a 20 MHz system clock and one channel module per pulse input.
`default_nettype none
package pic_pkg;
    // Counting modes
    typedef enum logic [1:0] {
        PIC_MODE_ADD     = 2'h0,
        PIC_MODE_INSTANT = 2'h1,
        PIC_MODE_SPEED   = 2'h2
    } pic_mode_t;

    localparam int unsigned CLK_HZ        = 20000000;
    localparam int unsigned TICK_MS       = 10;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned WINDOW_MS     = 1000;
    localparam int unsigned WINDOW_SLOTS  = WINDOW_MS / TICK_MS;
    localparam int unsigned VALUE_W       = 16;
    localparam logic [15:0] SAT_LIMIT     = 16'hFFFF;
    localparam int unsigned WRAP_FACTOR   = 20;
    localparam logic [15:0] VALUE_RESET   = 16'h0000;
endpackage
`default_nettype wire

// ---- design/pic_in_sync.sv ----
// Three-stage synchroniser for an external pulse pin.
// Assumes an asynchronous pin; output changes once stages two and three agree.
`default_nettype none
module pic_in_sync (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    // Pin and qualified level
    input  wire logic pin_i,
    output logic      level_o
);
    logic [2:0] sync_q;
    logic       level_q;

    // Only stage two and three are compared; stage one feeds stage two alone
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], pin_i};
            if (sync_q[1] == sync_q[2]) begin
                level_q <= sync_q[2];
            end
        end
    end

    assign level_o = level_q;
endmodule
`default_nettype wire

// ---- design/pic_top.sv ----
// Two-channel pulse integration and rotational speed counter.
// Assumes start, sample and trigger pulses come from logic on sys_clk_i.
`default_nettype none
module pic_top #(
    // Speed window timing; a bench may shorten it to fit whole windows in a run
    parameter int unsigned TICK_LEN  = pic_pkg::TICK_CYCLES,
    parameter int unsigned WIN_SLOTS = pic_pkg::WINDOW_SLOTS
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // Pulse pins
    input  wire logic        count_input_a_i,
    input  wire logic        count_input_b_i,
    // Per-channel settings, index 0 is channel a
    input  wire logic [1:0]  fall_edge_i,
    input  wire logic [1:0]  thresh_4v_i,
    input  wire logic [3:0]  mode_i,
    input  wire logic [1:0]  zero_on_trig_i,
    input  wire logic [1:0]  wrap_i,
    input  wire logic [31:0] range_i,
    input  wire logic [31:0] trig_level_i,
    input  wire logic [1:0]  trig_src_i,
    // Recorder events
    input  wire logic        meas_start_i,
    input  wire logic        sample_i,
    input  wire logic        trigger_i,
    // Results
    output logic [15:0]      value_a_o,
    output logic [15:0]      value_b_o,
    output logic [1:0]       thresh_4v_o,
    output logic [1:0]       trig_block_o
);
    logic [22:0] div_q;
    logic        tick_q;
    logic [1:0]  thr_q;
    wire  [1:0]  lvl;
    wire  [1:0]  pins = {count_input_b_i, count_input_a_i};
    wire  [15:0] val [2];
    wire  [1:0]  blk;

    // 10 ms enable pulse for the speed window
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q  <= 23'h000000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (32'(div_q) == TICK_LEN - 1);
            div_q  <= (meas_start_i || 32'(div_q) == TICK_LEN - 1) ? 23'h000000 : div_q + 1'b1;
        end
    end

    // threshold select drives the comparator reference
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            thr_q <= 2'h0;
        end else begin
            thr_q <= thresh_4v_i;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_ch
        pic_in_sync u_sync (
            .sys_clk_i (sys_clk_i),
            .reset_i   (reset_i),
            .pin_i     (pins[c]),
            .level_o   (lvl[c])
        );
        pic_channel #(.SLOTS(WIN_SLOTS)) u_ch (
            .sys_clk_i      (sys_clk_i),
            .reset_i        (reset_i),
            .level_i        (lvl[c]),
            .fall_edge_i    (fall_edge_i[c]),
            .mode_i         (mode_i[2*c +: 2]),
            .zero_on_trig_i (zero_on_trig_i[c]),
            .is_trig_src_i  (trig_src_i[c]),
            .wrap_i         (wrap_i[c]),
            .range_i        (range_i[16*c +: 16]),
            .trig_level_i   (trig_level_i[16*c +: 16]),
            .meas_start_i   (meas_start_i),
            .sample_i       (sample_i),
            .trigger_i      (trigger_i),
            .tick_i         (tick_q),
            .value_o        (val[c]),
            .trig_block_o   (blk[c])
        );
    end

    assign value_a_o    = val[0];
    assign value_b_o    = val[1];
    assign thresh_4v_o  = thr_q;
    assign trig_block_o = blk;
endmodule
`default_nettype wire

// ---- tb/pic_pulse_src.sv ----
// Far-side model: a pulse source such as an encoder or a wattmeter.
// Assumes one start strobe per burst; the pin idles low between bursts.
`default_nettype none
module pic_pulse_src (
    // Clock
    input  wire logic       sys_clk_i,
    // Burst request
    input  wire logic       start_i,
    input  wire logic [5:0] count_i,
    input  wire logic       slow_i,
    // Pin and status
    output logic            pin_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Whole pulses only; slow bursts stretch both phases to test spacing
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            if (start_i) begin
                busy_o = 1'b1;
                repeat (count_i) begin
                    #5 pin_o = 1'b1;
                    repeat (slow_i ? 6 : 3) @(posedge sys_clk_i);
                    #5 pin_o = 1'b0;
                    repeat (slow_i ? 6 : 3) @(posedge sys_clk_i);
                end
                busy_o = 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/pic_top_asserts.sv ----
// Port checks for the two-channel pulse counter top.
// Assumes settings change only shortly before a start pulse.
`default_nettype none
module pic_top_asserts (
    // Clock and reset
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    // Settings and events
    input wire logic [1:0]  thresh_4v_i,
    input wire logic [3:0]  mode_i,
    input wire logic [1:0]  zero_on_trig_i,
    input wire logic [1:0]  wrap_i,
    input wire logic [31:0] range_i,
    input wire logic [1:0]  trig_src_i,
    input wire logic        meas_start_i,
    input wire logic        sample_i,
    input wire logic        trigger_i,
    // Results
    input wire logic [15:0] value_a_o,
    input wire logic [15:0] value_b_o,
    input wire logic [1:0]  thresh_4v_o,
    input wire logic [1:0]  trig_block_o
);
    logic trig_seen_q;
    // Trigger seen since start, so the non-source zero check knows when to stop
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            trig_seen_q <= 1'b0;
        end else if (meas_start_i || trigger_i) begin
            trig_seen_q <= trigger_i;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    AST_RESET_ZERO: assert property (disable iff (1'b0)
        reset_i && $past(reset_i) |-> value_a_o == 16'h0000 && value_b_o == 16'h0000) else $error("value kept in reset");
    AST_START_CLEAR: assert property (
        meas_start_i |=> value_a_o == 16'h0000 && value_b_o == 16'h0000) else $error("start did not clear");
    AST_THRESH_REG: assert property (
        !$past(reset_i) |-> thresh_4v_o == $past(thresh_4v_i)) else $error("threshold not passed on");
    AST_STAND_A: assert property (
        !sample_i && !meas_start_i |=> $stable(value_a_o)) else $error("value a moved between samples");
    AST_STAND_B: assert property (
        !sample_i && !meas_start_i |=> $stable(value_b_o)) else $error("value b moved between samples");
    AST_NONSRC_ZERO: assert property (
        sample_i && zero_on_trig_i[1] && !trig_src_i[1] && mode_i[3:2] != 2'h2 && !trig_seen_q
        |=> value_b_o == 16'h0000) else $error("non-source value before trigger");
    AST_SAT_MONO: assert property (
        sample_i && mode_i[1:0] == 2'h0 && !wrap_i[0] && !zero_on_trig_i[0] && !meas_start_i
        |=> value_a_o >= $past(value_a_o)) else $error("saturating total fell");
    AST_WRAP_BOUND: assert property (
        sample_i && mode_i[3:2] == 2'h0 && wrap_i[1]
        |=> 21'(value_b_o) < 21'(range_i[31:16]) * 21'd20) else $error("wrapped total too large");
    cover property (sample_i && trigger_i);
    cover property (trig_block_o[0]);
    cover property (sample_i && mode_i[1:0] == 2'h1);
    cover property (sample_i && mode_i[1:0] == 2'h2);
endmodule
bind pic_top pic_top_asserts u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .thresh_4v_i(thresh_4v_i),
    .mode_i(mode_i), .zero_on_trig_i(zero_on_trig_i), .wrap_i(wrap_i), .range_i(range_i),
    .trig_src_i(trig_src_i), .meas_start_i(meas_start_i), .sample_i(sample_i), .trigger_i(trigger_i),
    .value_a_o(value_a_o), .value_b_o(value_b_o), .thresh_4v_o(thresh_4v_o), .trig_block_o(trig_block_o));
`default_nettype wire

// ---- tb/tb_pulse_integration_counter.sv ----
// Self-checking bench for the two-channel pulse counter.
// Assumes a pulse source on each pin; range is one count per division.
`default_nettype none
module tb_pulse_integration_counter;
    timeunit 1ns;
    timeprecision 1ns;
    // Short speed window so that a whole window fits in the run
    localparam int TB_TICK  = 200;
    localparam int TB_SLOTS = 8;
    logic        sys_clk_i, reset_i, meas_start_i, sample_i, trigger_i, pin_a, pin_b, busy_a, busy_b, go, slow;
    logic [1:0]  fall_edge_i, thresh_4v_i, zero_on_trig_i, wrap_i, trig_src_i, thresh_4v_o, trig_block_o;
    logic [3:0]  mode_i;
    logic [5:0]  n_a, n_b;
    logic [31:0] trig_level_i, lfsr, range_v;
    logic [15:0] value_a_o, value_b_o;
    int          failures, check_count;
    always #25 sys_clk_i = ~sys_clk_i;
    pic_top #(.TICK_LEN(TB_TICK), .WIN_SLOTS(TB_SLOTS)) DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .count_input_a_i(pin_a), .count_input_b_i(pin_b),
        .fall_edge_i(fall_edge_i), .thresh_4v_i(thresh_4v_i), .mode_i(mode_i), .zero_on_trig_i(zero_on_trig_i),
        .wrap_i(wrap_i), .range_i(range_v), .trig_level_i(trig_level_i), .trig_src_i(trig_src_i),
        .meas_start_i(meas_start_i), .sample_i(sample_i), .trigger_i(trigger_i), .value_a_o(value_a_o),
        .value_b_o(value_b_o), .thresh_4v_o(thresh_4v_o), .trig_block_o(trig_block_o));
    pic_pulse_src SRC_A (.sys_clk_i(sys_clk_i), .start_i(go), .count_i(n_a), .slow_i(slow), .pin_o(pin_a),
        .busy_o(busy_a));
    pic_pulse_src SRC_B (.sys_clk_i(sys_clk_i), .start_i(go), .count_i(n_b), .slow_i(slow), .pin_o(pin_b),
        .busy_o(busy_b));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #5;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One-cycle events, bits are start, sample, trigger
    task automatic strobe(input logic [2:0] w);
        {meas_start_i, sample_i, trigger_i} = w;
        tick(1);
        {meas_start_i, sample_i, trigger_i} = 3'h0;
        tick(2);
    endtask
    // Both sources fire together; a bounded wait, then time for the synchroniser
    task automatic burst(input logic [5:0] a, input logic [5:0] b);
        int t;
        n_a = a;
        n_b = b;
        slow = lfsr[16];
        go = 1'b1;
        tick(1);
        go = 1'b0;
        t = 0;
        while ((busy_a || busy_b) && t < 3000) begin
            tick(1);
            t++;
        end
        tick(8);
    endtask
    function automatic logic [31:0] lfsr_step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // A short burst fits in one speed window, so speed is the whole count; wrap point is twenty ranges
    function automatic logic [15:0] want(input int m, input logic w, input logic [5:0] n, input logic [15:0] r);
        if (m == 2)
            return 16'(n);
        return (m == 0 && w) ? 16'(n % (20 * r)) : 16'(n);
    endfunction
    initial begin
        #3000000;
        failures++;
        print_verdict();
    end
    initial begin
        {sys_clk_i, meas_start_i, sample_i, trigger_i, go, slow, fall_edge_i, thresh_4v_i} = '0;
        {zero_on_trig_i, wrap_i, trig_src_i, mode_i, n_a, n_b, failures, check_count} = '0;
        reset_i = 1'b1;
        trig_level_i = 32'hFFFFFFFF;
        range_v = 32'h00010001;
        lfsr = 32'h17241A9D;
        tick(20);
        reset_i = 1'b0;
        check(value_a_o | value_b_o, 16'h0000);
        tick(2);
        // Every mode, both edges and both overflow policies, split across channels
        for (int k = 0; k < 6; k++) begin
            lfsr = lfsr_step(lfsr);
            mode_i = {2'(k % 3), 2'(k % 3)};
            fall_edge_i = (k % 2) ? 2'h1 : 2'h2;
            wrap_i = (k > 2) ? 2'h1 : 2'h2;
            thresh_4v_i = lfsr[9:8];
            range_v[15:0] = (k == 3) ? 16'h0001 : 16'(1 + lfsr[17]);
            range_v[31:16] = (k == 0) ? 16'h0001 : 16'(1 + lfsr[18]);
            strobe(3'h4);
            burst((k == 3) ? 6'd23 : lfsr[5:0], (k == 0) ? 6'd40 : lfsr[15:10]);
            // Let one more interval close so the last pulses reach the speed sum
            if (k % 3 == 2) begin
                tick(TB_TICK + 4);
            end
            strobe(3'h2);
            check(value_a_o, want(k % 3, wrap_i[0], n_a, range_v[15:0]));
            check(value_b_o, want(k % 3, wrap_i[1], n_b, range_v[31:16]));
            check({14'h0, thresh_4v_o}, {14'h0, thresh_4v_i});
            // A full quiet window empties the speed sum
            if (k % 3 == 2) begin
                tick((TB_SLOTS + 1) * TB_TICK);
            end
            strobe(3'h2);
            check(value_a_o, (k % 3 == 0) ? want(0, wrap_i[0], n_a, range_v[15:0]) : 16'h0000);
            check(value_b_o, (k % 3 == 0) ? want(0, wrap_i[1], n_b, range_v[31:16]) : 16'h0000);
        end
        mode_i = 4'h0;
        wrap_i = 2'h0;
        zero_on_trig_i = 2'h3;
        trig_src_i = 2'h1;
        strobe(3'h4);
        burst(6'd7, 6'd5);
        strobe(3'h2);
        check(value_b_o, 16'h0000);
        strobe(3'h3);
        check(value_a_o, 16'h0007);
        check(value_b_o, 16'h0000);
        strobe(3'h2);
        check(value_a_o, 16'h0007);
        check(value_b_o, 16'h0000);
        burst(6'd3, 6'd4);
        strobe(3'h2);
        check(value_a_o, 16'h0003);
        check(value_b_o, 16'h0004);
        trig_level_i = 32'h00000002;
        strobe(3'h4);
        burst(6'd5, 6'd0);
        strobe(3'h2);
        check({15'h0, trig_block_o[0]}, 16'h0001);
        strobe(3'h3);
        check({15'h0, trig_block_o[0]}, 16'h0000);
        print_verdict();
    end
endmodule
`default_nettype wire
